// *** pulse_trig_pkg.sv ***
// Constants for the pulse output trigger and mode control block.
// Notes on behaviour
// (R1) 8-bit trigger select register, per group channel.
// (R2) Trigger select resets to 0xFF, kept otherwise.
// (R3) Bits 7:6 pick channel for group 3.
// (R4) Bits 5:4 pick channel for group 2.
// (R5) Bits 3:2 pick channel for group 1.
// (R6) Bits 1:0 pick channel for group 0.
// (R7) 8-bit mode register, normal or non-overlap per group.
// (R8) Mode register resets to 0xF0, kept otherwise.
// (R9) Mode bits 7:4 read one, ignore writes.
// (R10) Normal mode: update only at compare A.
// (R11) Non-overlap: change at compare A and B.
// (R12) Timer sets trigger period in register B.
// (R13) Timer sets non-overlap margin in register A.
// (R14) Enabled staged bits copy to port data.
// (R15) Non-overlap: B copies only zero staged bits.
// (R16) Capture on register A replaces compare A.
// (R17) Timer gives one-clock A and B pulses.
// (R18) Configuration sampled in same clock as event.
package pulse_trig_pkg;
  localparam int unsigned NUM_GROUPS     = 4;
  localparam int unsigned NUM_CHANNELS   = 4;
  localparam int unsigned GROUP_WIDTH    = 4;
  localparam int unsigned SEL_WIDTH      = 2;
  localparam int unsigned PIN_WIDTH      = 16;
  localparam int unsigned REG_WIDTH      = 8;
  localparam int unsigned ADDR_WIDTH     = 4;
  localparam int unsigned DATA_WIDTH     = 32;
  localparam int unsigned NUM_REGS       = 2;
  localparam logic [3:0]  ADDR_TRIG_SEL  = 4'h0;
  localparam logic [3:0]  ADDR_OUT_MODE  = 4'h4;
  localparam logic [7:0]  TRIG_SEL_RESET = 8'hFF;
  localparam logic [7:0]  OUT_MODE_RESET = 8'hF0;
  localparam logic [7:0]  OUT_MODE_FIXED = 8'hF0;
  localparam logic [7:0]  OUT_MODE_WMASK = 8'h0F;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : pulse_trig_pkg

// *** cfg_reg_if.sv ***
// Interface carrying register file write and read ports.
`timescale 1ns/1ns
interface cfg_reg_if;
  logic                                     wr_en;
  logic [pulse_trig_pkg::ADDR_WIDTH-1:0]    wr_idx;
  logic [pulse_trig_pkg::REG_WIDTH-1:0]     wr_data;
  logic                                     rd_en;
  logic [pulse_trig_pkg::ADDR_WIDTH-1:0]    rd_idx;
  logic [pulse_trig_pkg::REG_WIDTH-1:0]     rd_data;
  logic [pulse_trig_pkg::REG_WIDTH-1:0]     trig_sel;
  logic [pulse_trig_pkg::REG_WIDTH-1:0]     out_mode;
  modport master (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, trig_sel, out_mode);
  modport store  (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, trig_sel, out_mode);
endinterface : cfg_reg_if

// *** cfg_reg_store.sv ***
// Two configuration registers with registered read data.
`timescale 1ns/1ns
module cfg_reg_store (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  cfg_reg_if.store  regs
);
  logic [7:0] trig_sel_q;
  logic [7:0] out_mode_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_mux;
  logic       wr_trig;
  logic       wr_mode;

  assign wr_trig = regs.wr_en && (regs.wr_idx == pulse_trig_pkg::ADDR_TRIG_SEL);
  assign wr_mode = regs.wr_en && (regs.wr_idx == pulse_trig_pkg::ADDR_OUT_MODE);
  assign rd_mux  = (regs.rd_idx == pulse_trig_pkg::ADDR_TRIG_SEL) ? trig_sel_q :
                   (regs.rd_idx == pulse_trig_pkg::ADDR_OUT_MODE) ? out_mode_q : 8'h00;

  // Reset stands in for hardware standby; there is no software standby input, so contents persist.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      trig_sel_q <= pulse_trig_pkg::TRIG_SEL_RESET; // R2
      out_mode_q <= pulse_trig_pkg::OUT_MODE_RESET; // R8
      rd_data_q  <= 8'h00;
    end else begin
      if (wr_trig) begin
        trig_sel_q <= regs.wr_data; // R1
      end
      if (wr_mode) begin
        out_mode_q <= pulse_trig_pkg::OUT_MODE_FIXED | (regs.wr_data & pulse_trig_pkg::OUT_MODE_WMASK); // R7 R9
      end
      if (regs.rd_en) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign regs.rd_data  = rd_data_q;
  assign regs.trig_sel = trig_sel_q;
  assign regs.out_mode = out_mode_q;
endmodule : cfg_reg_store

// *** pulse_trig_ctrl.sv ***
// Pulse output trigger select and mode control with AXI4-Lite registers.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pulse_trig_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [3:0]  cmp_match_a_i,
  input  wire logic [3:0]  cmp_match_b_i,
  input  wire logic [3:0]  capture_a_i,
  input  wire logic [3:0]  gra_is_capture_i,
  input  wire logic [15:0] staged_next_data_i,
  input  wire logic [15:0] staged_data_enable_i,
  output logic [15:0]      port_data_o,
  output logic [15:0]      port_load_o
);
  cfg_reg_if regs ();

  cfg_reg_store u_store (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .regs       (regs)
  );

  // Write channel: address and data may arrive in either order.
  logic        aw_held_q;
  logic [3:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_take;
  logic        w_take;
  logic        wr_go;
  logic [3:0]  wr_addr;
  logic        wr_hit;

  assign aw_take = s_axi_awvalid_i && !aw_held_q && !bvalid_q;
  assign w_take  = s_axi_wvalid_i && !w_held_q && !bvalid_q;
  assign wr_go   = aw_held_q && w_held_q && !bvalid_q;
  assign wr_addr = {aw_addr_q[3:2], 2'b00};
  assign wr_hit  = (wr_addr == pulse_trig_pkg::ADDR_TRIG_SEL) || (wr_addr == pulse_trig_pkg::ADDR_OUT_MODE);

  // Registers are one byte wide, so only lane 0 matters.
  assign regs.wr_en   = wr_go && wr_hit && w_strb_q[0];
  assign regs.wr_idx  = wr_addr;
  assign regs.wr_data = w_data_q[7:0];

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata_i;
      w_strb_q <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pulse_trig_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? pulse_trig_pkg::RESP_OKAY : pulse_trig_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // The ready outputs are registered copies of the acceptance terms, so they are pulses one cycle after the take.
  logic awready_q;
  logic wready_q;
  logic arready_q;

  // Read channel: one read in flight, answered two cycles after acceptance.
  logic        rd_pend_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic        rd_hit_q;
  logic [3:0]  ar_addr;
  logic        ar_take;
  logic        rd_hit;

  assign ar_addr     = {s_axi_araddr_i[3:2], 2'b00};
  assign ar_take     = s_axi_arvalid_i && !rd_pend_q && !rvalid_q && !arready_q;
  assign rd_hit      = (ar_addr == pulse_trig_pkg::ADDR_TRIG_SEL) || (ar_addr == pulse_trig_pkg::ADDR_OUT_MODE);
  assign regs.rd_en  = ar_take;
  assign regs.rd_idx = ar_addr;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= aw_take;
      wready_q  <= w_take;
      arready_q <= ar_take;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_pend_q <= 1'b0;
      rd_hit_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= pulse_trig_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rd_pend_q <= 1'b1;
      rd_hit_q  <= rd_hit;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rd_hit_q ? pulse_trig_pkg::RESP_OKAY : pulse_trig_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // Trigger path. Timer pulses are on this clock, so they go straight in.
  logic [15:0] port_data_q;
  logic [15:0] port_load_q;
  logic [15:0] port_data_d;
  logic [15:0] load_d;

  genvar g;
  generate
    for (g = 0; g < pulse_trig_pkg::NUM_GROUPS; g++) begin : gen_group
      localparam int unsigned SW = pulse_trig_pkg::SEL_WIDTH;
      localparam int unsigned GW = pulse_trig_pkg::GROUP_WIDTH;
      logic [1:0] chan;
      logic       nonovl;
      logic       ev_a;
      logic       ev_b;
      logic [3:0] nd;
      logic [3:0] en;
      logic [3:0] cur;
      logic [3:0] take_a;
      logic [3:0] take_b;

      // Live register values are used, so a write in the event cycle's prior edge applies.
      assign chan   = regs.trig_sel[SW*g +: SW]; // R3 R4 R5 R6 R18
      assign nonovl = regs.out_mode[g];
      // Capture stands in for compare A when register A is a capture register.
      assign ev_a   = gra_is_capture_i[chan] ? capture_a_i[chan] : cmp_match_a_i[chan]; // R16 R17
      assign ev_b   = nonovl && cmp_match_b_i[chan]; // R11 R12 R13
      assign nd     = staged_next_data_i[GW*g +: GW];
      assign en     = staged_data_enable_i[GW*g +: GW];
      assign cur    = port_data_q[GW*g +: GW];
      assign take_a = ev_a ? en : 4'h0; // R10 R14
      assign take_b = ev_b ? (en & ~nd) : 4'h0; // R15
      assign load_d[GW*g +: GW]      = take_a | take_b;
      assign port_data_d[GW*g +: GW] = ((take_a | take_b) & nd) | (~(take_a | take_b) & cur);
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port_data_q <= 16'h0000;
      port_load_q <= 16'h0000;
    end else begin
      port_data_q <= port_data_d;
      port_load_q <= load_d;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rdata_o   = {24'h00_0000, regs.rd_data};
  assign port_data_o     = port_data_q;
  assign port_load_o     = port_load_q;
endmodule : pulse_trig_ctrl

// *** timer_stub.sv ***
// Stand-in timer that turns bench requests into one-clock event pulses.
`timescale 1ns/1ns
module timer_stub (
  input  wire logic [3:0] fire_a_i,
  input  wire logic [3:0] fire_b_i,
  input  wire logic [3:0] fire_c_i,
  input  wire logic       core_clk_i,
  output logic      [3:0] cmp_match_a_o,
  output logic      [3:0] cmp_match_b_o,
  output logic      [3:0] capture_a_o
);
  // Events leave a register, as a real timer's do, so they never race the clock edge.
  always_ff @(posedge core_clk_i) begin
    cmp_match_a_o <= fire_a_i;
    cmp_match_b_o <= fire_b_i;
    capture_a_o   <= fire_c_i;
  end
endmodule : timer_stub

// *** pulse_trig_ctrl_properties.sv ***
// Checker for port data transfers and register bus answers.
`timescale 1ns/1ns
module pulse_trig_chk (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [3:0]  cmp_match_a_i,
  input wire logic [3:0]  cmp_match_b_i,
  input wire logic [3:0]  capture_a_i,
  input wire logic [15:0] staged_next_data_i,
  input wire logic [15:0] staged_data_enable_i,
  input wire logic [15:0] port_data_o,
  input wire logic [15:0] port_load_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wacc; s_axi_awready_o && s_axi_wready_o; endsequence
  sequence s_bonly; cmp_match_b_i != 4'h0 && cmp_match_a_i == 4'h0 && capture_a_i == 4'h0; endsequence
  property p_rd_width; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000; endproperty
  property p_ld_en; (port_load_o & ~$past(staged_data_enable_i)) == 16'h0000; endproperty
  property p_ld_val; (port_data_o & port_load_o) == ($past(staged_next_data_i) & port_load_o); endproperty
  property p_keep; (port_data_o & ~port_load_o) == ($past(port_data_o) & ~port_load_o); endproperty
  property p_ld_cause; port_load_o != 16'h0000 |-> $past(cmp_match_a_i | cmp_match_b_i | capture_a_i) != 4'h0;
  endproperty
  property p_b_zero; s_bonly ##1 port_load_o != 16'h0000 |-> (port_data_o & port_load_o) == 16'h0000; endproperty
  property p_bresp; s_wacc |-> ##[1:2] s_axi_bvalid_o; endproperty
  property p_bone; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  a_rd_width: assert property (p_rd_width) else $error("read data wider than a byte");
  a_ld_en: assert property (p_ld_en) else $error("disabled bit loaded");
  a_ld_val: assert property (p_ld_val) else $error("loaded bit differs from staged");
  a_keep: assert property (p_keep) else $error("unloaded bit changed");
  a_ld_cause: assert property (p_ld_cause) else $error("load without event");
  a_b_zero: assert property (p_b_zero) else $error("one copied at compare B");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_bone: assert property (p_bone) else $error("write response not released");
endmodule : pulse_trig_chk
bind pulse_trig_ctrl pulse_trig_chk chk (.*);

// *** pulse_trig_ctrl_bench.sv ***
// Self-checking bench for the pulse trigger and mode control block.
`timescale 1ns/1ns
module pulse_output_trigger_mode_control_bench;
  typedef struct packed {logic [7:0] sel, mode; logic [3:0] a, b; logic [15:0] nxt, en, exp, ld;} row_t;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0, fa = 4'h0, fb = 4'h0, fc = 4'h0, cap = 4'h0, ws = 4'hf, ma, mb, mc;
  logic [31:0] wd = 32'h0000_0000, rd_q;
  logic [15:0] nxt = 16'h0000, en = 16'h0000, pd, pl;
  logic [1:0]  bresp, rresp;
  logic        awr, wr_rdy, bv, arr, rv;
  int          err_count = 0;
  int          checks = 0;
  row_t        rows [7];
  timer_stub tmr (.core_clk_i(clk), .fire_a_i(fa), .fire_b_i(fb), .fire_c_i(fc),
    .cmp_match_a_o(ma), .cmp_match_b_o(mb), .capture_a_o(mc));
  pulse_trig_ctrl dut (.core_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd_q),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .cmp_match_a_i(ma),
    .cmp_match_b_i(mb), .capture_a_i(mc), .gra_is_capture_i(cap), .staged_next_data_i(nxt),
    .staged_data_enable_i(en), .port_data_o(pd), .port_load_o(pl));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] ad, logic [7:0] d, logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    {awa, wd, awv, wv, br} <= {ad, 24'h00_0000, d, 3'b111};
    do begin
      @(posedge clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_rdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 20);
    br <= 1'b0;
    chk("bvalid", 1, bv);
    if (bv !== 1'b1) give_verdict();
    chk("bresp", er, bresp);
  endtask : wr
  task automatic rd(logic [3:0] ad, logic [7:0] e, logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    {ara, arv, rr} <= {ad, 2'b11};
    do begin
      @(posedge clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 20);
    rr <= 1'b0;
    chk("rvalid", 1, rv);
    if (rv !== 1'b1) give_verdict();
    chk("rdata", {24'h00_0000, e}, rd_q);
    chk("rresp", er, rresp);
  endtask : rd
  // Two edges pass from request to port: one in the timer, one in the block.
  // The load pulse stands for one cycle only, so it is read at the same edge as the port data.
  task automatic fire(logic [3:0] a, logic [3:0] b, logic [3:0] c, logic [15:0] e, logic [15:0] l);
    @(posedge clk);
    {fa, fb, fc} <= {a, b, c};
    @(posedge clk);
    {fa, fb, fc} <= 12'h000;
    repeat (2) @(posedge clk);
    chk("port_data", {16'h0000, e}, {16'h0000, pd});
    chk("port_load", {16'h0000, l}, {16'h0000, pl});
  endtask : fire
  initial forever #4 clk = ~clk;
  initial begin
    rows[0] = '{8'h1b, 8'h00, 4'h1, 4'h0, 16'hffff, 16'h3000, 16'h3000, 16'h3000};
    rows[1] = '{8'h1b, 8'h00, 4'h4, 4'h0, 16'h5555, 16'h00ff, 16'h3050, 16'h00f0};
    rows[2] = '{8'he4, 8'h00, 4'h0, 4'h8, 16'h0000, 16'hffff, 16'h3050, 16'h0000};
    rows[3] = '{8'he4, 8'h00, 4'h8, 4'h0, 16'h0000, 16'hffff, 16'h0050, 16'hf000};
    rows[4] = '{8'he4, 8'h0f, 4'h0, 4'h2, 16'h00a0, 16'hffff, 16'h0000, 16'h0050};
    rows[5] = '{8'he4, 8'h0f, 4'h2, 4'h0, 16'h00a0, 16'hffff, 16'h00a0, 16'h00f0};
    // Both compare events in one cycle: the union of loads copies the staged value.
    rows[6] = '{8'he4, 8'h0f, 4'h2, 4'h2, 16'h0050, 16'hffff, 16'h0050, 16'h00f0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'hff, 2'b00);
    rd(4'h4, 8'hf0, 2'b00);
    foreach (rows[i]) begin
      wr(4'h0, rows[i].sel, 2'b00);
      wr(4'h4, rows[i].mode, 2'b00);
      {nxt, en} <= {rows[i].nxt, rows[i].en};
      fire(rows[i].a, rows[i].b, 4'h0, rows[i].exp, rows[i].ld);
      $display("row %0d done", i);
    end
    wr(4'h4, 8'h05, 2'b00);
    rd(4'h4, 8'hf5, 2'b00);
    wr(4'h8, 8'h12, 2'b10);
    rd(4'h8, 8'h00, 2'b10);
    rd(4'h0, 8'he4, 2'b00);
    // A write with byte lane 0 off is answered but leaves the register alone.
    ws <= 4'h0;
    wr(4'h0, 8'h00, 2'b00);
    ws <= 4'hf;
    rd(4'h0, 8'he4, 2'b00);
    $display("register access done");
    {cap, nxt} <= {4'h8, 16'hf000};
    fire(4'h8, 4'h0, 4'h0, 16'h0050, 16'h0000);
    fire(4'h0, 4'h0, 4'h8, 16'hf050, 16'hf000);
    $display("capture trigger done");
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk("port_data", 0, {16'h0000, pd});
    rd(4'h0, 8'hff, 2'b00);
    rd(4'h4, 8'hf0, 2'b00);
    $display("second reset done");
    give_verdict();
  end
endmodule : pulse_output_trigger_mode_control_bench
